// *** core/dsim_regs.svh ***
`ifndef DSIM_REGS_SVH
`define DSIM_REGS_SVH

// Register map, byte addresses
`define DSIM_ADDR_W          8
`define DSIM_REG_IRQ_STATUS  8'h00
`define DSIM_REG_IRQ_CLEAR   8'h04
`define DSIM_REG_IRQ_ENABLE  8'h08
`define DSIM_REG_CONTROL     8'h0C
`define DSIM_REG_ASM71       8'h10
`define DSIM_REG_ASM70       8'h14
`define DSIM_REG_POLES       8'h18
`define DSIM_REG_SPEED       8'h1C

// Interrupt event bit positions
`define DSIM_EV_W            5
`define DSIM_EV_FAULT_SET    0
`define DSIM_EV_FAULT_CLR    1
`define DSIM_EV_AT_REF       2
`define DSIM_EV_SPEED_UPD    3
`define DSIM_EV_POLE_ZERO    4

// Control register fields and reset value
`define DSIM_CTRL_W          2
`define DSIM_CTRL_SPEED_EN   0
`define DSIM_CTRL_FREEZE     1
`define DSIM_CTRL_RESET      2'h1

// Operation status word bit positions
`define DSIM_OSW_FWD         0
`define DSIM_OSW_REV         1
`define DSIM_OSW_ACC         9
`define DSIM_OSW_DEC         10
`define DSIM_OSW_ALM         11

// Drive state codes of the control supervisor
`define DSIM_DS_READY        8'h03
`define DSIM_DS_ENABLED      8'h04
`define DSIM_DS_STOPPING     8'h05

// Speed conversion constants
`define DSIM_RPM_FACTOR      7'h78
`define DSIM_FREQ_SCALE      7'h64
`define DSIM_SPEED_MAX       16'hFFFF

// Speed refresh period
`define DSIM_CLK_MHZ         250
`define DSIM_UPD_NS          1000
`define DSIM_UPD_CYC         ((`DSIM_UPD_NS * `DSIM_CLK_MHZ) / 1000)
`define DSIM_UPD_CNT_W       9

`endif

// *** core/dsim_pkg.sv ***
package dsim_pkg;

  // Pole count capture after reset release
  typedef enum logic [1:0] {
    BT_SETTLE,
    BT_LATCH,
    BT_RUN
  } dsim_boot_t;

  // Speed computation sequencing
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_CALC,
    SP_STORE
  } dsim_speed_t;

endpackage : dsim_pkg

// *** core/dsim_rpm_divider.sv ***
`timescale 1ns/1ps
`include "dsim_regs.svh"
module dsim_rpm_divider
  import dsim_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] numer,
  input  wire logic [15:0] denom,
  // Result
  output logic             busy,
  output logic             done,
  output logic [15:0]      quot
);

  logic [31:0] num_ff;
  logic [31:0] q_ff;
  logic [16:0] rem_ff;
  logic [15:0] den_ff;
  logic [5:0]  cnt_ff;
  logic [16:0] trial;
  logic [16:0] shifted;

  // One quotient bit per cycle keeps the datapath small; 32 cycles per result
  assign shifted = {rem_ff[15:0], num_ff[31]};
  assign trial   = shifted - {1'b0, den_ff};

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      num_ff <= 32'h0;
      q_ff   <= 32'h0;
      rem_ff <= 17'h0;
      den_ff <= 16'h0;
      cnt_ff <= 6'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        num_ff <= numer;
        den_ff <= denom;
        rem_ff <= 17'h0;
        q_ff   <= 32'h0;
        cnt_ff <= 6'h20;
        busy   <= 1'b1;
      end
      else if (busy)
      begin
        num_ff <= {num_ff[30:0], 1'b0};
        if (!trial[16])
        begin
          rem_ff <= trial;
          q_ff   <= {q_ff[30:0], 1'b1};
        end
        else
        begin
          rem_ff <= shifted;
          q_ff   <= {q_ff[30:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 6'h1;
        if (cnt_ff == 6'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Saturate rather than wrap on oversize results
  assign quot = (q_ff[31:16] != 16'h0) ? `DSIM_SPEED_MAX : q_ff[15:0];

endmodule : dsim_rpm_divider

// *** core/dsim_input_mapper.sv ***
// Behaviour
// - Faulted bit follows alarm bit 11 of the operation status word.
// - Warning bit always reads 0.
// - Running-forward bit equals operation status bit 0.
// - Running-reverse bit equals operation status bit 1.
// - Ready set in Ready, Enabled or Stopping drive state, else cleared.
// - Control-from-network and reference-from-network bits always 0.
// - At-reference when running and both accelerating and decelerating flags are 0.
// - Drive state byte carries the current control supervisor state code.
// - Speed actual RPM equals output frequency times 120 divided by pole count.
// - Pole count read once after reset; later changes need a restart.
// - Instance 71 and 70 byte layout; speed low byte first.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "dsim_regs.svh"
module dsim_input_mapper
  import dsim_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // Inverter side, asynchronous to sys_clk
  input  wire logic [15:0]              operation_status_word,
  input  wire logic [15:0]              output_frequency_code,
  input  wire logic [7:0]               motor_pole_count_setting,
  // Control supervisor, same clock
  input  wire logic [7:0]               drive_state,
  // Register port
  input  wire logic [`DSIM_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  // Input assemblies toward the network controller
  output logic [31:0]                   asm71_ff,
  output logic [31:0]                   asm70_ff,
  output logic                          irq_ff
);

  // Input synchronisers
  logic [15:0] osw_meta_ff;
  logic [15:0] osw_ff;
  logic [15:0] freq_meta_ff;
  logic [15:0] freq_ff;
  logic [7:0]  pole_meta_ff;
  logic [7:0]  pole_sync_ff;

  // Bit words are quasi-static; a torn sample lasts one cycle at most
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osw_meta_ff  <= 16'h0;
      osw_ff       <= 16'h0;
      freq_meta_ff <= 16'h0;
      freq_ff      <= 16'h0;
    end
    else
    begin
      osw_meta_ff  <= operation_status_word;
      osw_ff       <= osw_meta_ff;
      freq_meta_ff <= output_frequency_code;
      freq_ff      <= freq_meta_ff;
    end
  end

  // No reset: a cleared pipe would hand zero to the latch two edges after release
  always_ff @(posedge sys_clk)
  begin
    pole_meta_ff <= motor_pole_count_setting;
    pole_sync_ff <= pole_meta_ff;
  end

  // Pole count capture
  dsim_boot_t boot_ff;
  dsim_boot_t nxt_boot;
  logic [7:0] poles_ff;

  always_comb
  begin
    nxt_boot = boot_ff;
    case (boot_ff)
      BT_SETTLE: nxt_boot = BT_LATCH;
      BT_LATCH:  nxt_boot = BT_RUN;
      BT_RUN:    nxt_boot = BT_RUN;
      default:   nxt_boot = BT_SETTLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      boot_ff <= BT_SETTLE;
    else
      boot_ff <= nxt_boot;
  end

  // Captured only on the boot pass so a live edit has no effect until restart
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      poles_ff <= 8'h0;
    else if (boot_ff == BT_LATCH)
      poles_ff <= pole_sync_ff;
  end

  // Status bit decode
  logic faulted;
  logic run_fwd;
  logic run_rev;
  logic ready;
  logic at_ref;

  assign faulted = osw_ff[`DSIM_OSW_ALM];
  assign run_fwd = osw_ff[`DSIM_OSW_FWD];
  assign run_rev = osw_ff[`DSIM_OSW_REV];
  assign ready   = (drive_state == `DSIM_DS_READY) ||
                   (drive_state == `DSIM_DS_ENABLED) ||
                   (drive_state == `DSIM_DS_STOPPING);
  assign at_ref  = (run_fwd || run_rev) &&
                   !osw_ff[`DSIM_OSW_ACC] && !osw_ff[`DSIM_OSW_DEC];

  // Control register
  logic [`DSIM_CTRL_W-1:0] ctrl_ff;
  logic                    freeze;
  logic                    speed_en;

  assign speed_en = ctrl_ff[`DSIM_CTRL_SPEED_EN];
  assign freeze   = ctrl_ff[`DSIM_CTRL_FREEZE];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_ff <= `DSIM_CTRL_RESET;
    else if (reg_wr && reg_addr == `DSIM_REG_CONTROL)
      ctrl_ff <= reg_wdata[`DSIM_CTRL_W-1:0];
  end

  // Speed refresh tick
  logic [`DSIM_UPD_CNT_W-1:0] upd_cnt_ff;
  logic                       upd_tick_ff;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      upd_cnt_ff  <= '0;
      upd_tick_ff <= 1'b0;
    end
    else if (upd_cnt_ff == `DSIM_UPD_CNT_W'(`DSIM_UPD_CYC - 1))
    begin
      upd_cnt_ff  <= '0;
      upd_tick_ff <= 1'b1;
    end
    else
    begin
      upd_cnt_ff  <= upd_cnt_ff + `DSIM_UPD_CNT_W'(1);
      upd_tick_ff <= 1'b0;
    end
  end

  // Speed computation
  dsim_speed_t sp_ff;
  dsim_speed_t nxt_sp;
  logic [31:0] numer;
  logic [15:0] denom;
  logic        div_start;
  logic        div_busy;
  logic        div_done;
  logic [15:0] div_quot;
  logic [15:0] speed_ff;
  logic        pole_zero;

  // Frequency code is in hundredths of a hertz
  assign denom     = 16'(poles_ff * `DSIM_FREQ_SCALE);
  assign numer     = 32'(freq_ff * `DSIM_RPM_FACTOR) + {17'h0, denom[15:1]};
  assign pole_zero = (poles_ff == 8'h0);
  assign div_start = (sp_ff == SP_IDLE) && upd_tick_ff && speed_en &&
                     (boot_ff == BT_RUN) && !pole_zero;

  always_comb
  begin
    nxt_sp = sp_ff;
    case (sp_ff)
      SP_IDLE:  if (div_start) nxt_sp = SP_CALC;
      SP_CALC:  if (div_done) nxt_sp = SP_STORE;
      SP_STORE: nxt_sp = SP_IDLE;
      default:  nxt_sp = SP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sp_ff <= SP_IDLE;
    else
      sp_ff <= nxt_sp;
  end

  dsim_rpm_divider u_div (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (div_start),
    .numer   (numer),
    .denom   (denom),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

  // An unusable pole count reports zero speed rather than a stale value
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      speed_ff <= 16'h0;
    else if (boot_ff == BT_RUN && pole_zero)
      speed_ff <= 16'h0;
    else if (div_done)
      speed_ff <= div_quot;
  end

  // Assembly words; freeze holds the last image for a consistent read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      asm71_ff <= 32'h0;
      asm70_ff <= 32'h0;
    end
    else if (!freeze)
    begin
      asm71_ff <= {speed_ff, drive_state,
                   at_ref, 1'b0, 1'b0, ready,
                   run_rev, run_fwd, 1'b0, faulted};
      asm70_ff <= {speed_ff, 8'h00, 5'h00, run_fwd, 1'b0, faulted};
    end
  end

  // Interrupt events
  logic                  faulted_d_ff;
  logic                  at_ref_d_ff;
  logic                  pole_evt_ff;
  logic [`DSIM_EV_W-1:0] ev;
  logic [`DSIM_EV_W-1:0] irq_stat_ff;
  logic [`DSIM_EV_W-1:0] irq_en_ff;
  logic [`DSIM_EV_W-1:0] clr;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      faulted_d_ff <= 1'b0;
      at_ref_d_ff  <= 1'b0;
      pole_evt_ff  <= 1'b0;
    end
    else
    begin
      faulted_d_ff <= faulted;
      at_ref_d_ff  <= at_ref;
      pole_evt_ff  <= (boot_ff == BT_LATCH) && (pole_sync_ff == 8'h0);
    end
  end

  always_comb
  begin
    ev                     = '0;
    ev[`DSIM_EV_FAULT_SET] = faulted && !faulted_d_ff;
    ev[`DSIM_EV_FAULT_CLR] = !faulted && faulted_d_ff;
    ev[`DSIM_EV_AT_REF]    = at_ref && !at_ref_d_ff;
    ev[`DSIM_EV_SPEED_UPD] = div_done;
    ev[`DSIM_EV_POLE_ZERO] = pole_evt_ff;
  end

  assign clr = (reg_wr && reg_addr == `DSIM_REG_IRQ_CLEAR) ?
               reg_wdata[`DSIM_EV_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_en_ff <= '0;
    else if (reg_wr && reg_addr == `DSIM_REG_IRQ_ENABLE)
      irq_en_ff <= reg_wdata[`DSIM_EV_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(((irq_stat_ff & ~clr) | ev) & irq_en_ff);
  end

  // Register read, data valid the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DSIM_REG_IRQ_STATUS: reg_rdata <= {27'h0, irq_stat_ff};
        `DSIM_REG_IRQ_ENABLE: reg_rdata <= {27'h0, irq_en_ff};
        `DSIM_REG_CONTROL:    reg_rdata <= {30'h0, ctrl_ff};
        `DSIM_REG_ASM71:      reg_rdata <= asm71_ff;
        `DSIM_REG_ASM70:      reg_rdata <= asm70_ff;
        `DSIM_REG_POLES:      reg_rdata <= {24'h0, poles_ff};
        `DSIM_REG_SPEED:      reg_rdata <= {15'h0, div_busy, speed_ff};
        default:              reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

endmodule : dsim_input_mapper

// *** tb/dsim_net_ctrl.sv ***
`timescale 1ns/1ps
module dsim_net_ctrl
  import dsim_pkg::*;
(
  // Assembly seen by the controller
  input  wire logic [31:0] asm_in,
  // Decoded fields
  output logic             faulted,
  output logic [15:0]      speed_rpm
);
  // Controller selects instance 71 with output 21
  localparam int IN_INST = 71;
  assign faulted   = asm_in[0];
  assign speed_rpm = {asm_in[31:24], asm_in[23:16]};
endmodule : dsim_net_ctrl

// *** tb/dsim_input_mapper_sva.sv ***
`timescale 1ns/1ps
`include "dsim_regs.svh"
module dsim_input_mapper_chk
  import dsim_pkg::*;
(
  // Watched ports
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] operation_status_word,
  input  wire logic [7:0]  drive_state,
  input  wire logic [31:0] asm71_ff,
  input  wire logic [31:0] asm70_ff,
  // Register writes, to follow the freeze bit
  input  wire logic [`DSIM_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr
);
  logic [2:0] age_ff;
  logic       ok;
  // Past values are only meaningful once the sync pipe has filled
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      age_ff <= 3'h0;
    else if (age_ff != 3'h4)
      age_ff <= age_ff + 3'h1;
  end
  assign ok = (age_ff == 3'h4);
  logic       frz_ff;
  // Images are held while frozen, so the follow checks skip those cycles
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      frz_ff <= 1'b0;
    else if (reg_wr && reg_addr == `DSIM_REG_CONTROL)
      frz_ff <= reg_wdata[`DSIM_CTRL_FREEZE];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_warn_zero: assert property (asm71_ff[1] == 1'b0) else $error("warning bit set");
  a_net_bits_zero: assert property (asm71_ff[6:5] == 2'h0) else $error("network bits set");
  a_fault_follow: assert property (ok && !$past(frz_ff) |->
    asm71_ff[0] == $past(operation_status_word[11], 3) && asm70_ff[0] == asm71_ff[0])
    else $error("faulted bit wrong");
  a_fwd_follow: assert property (ok && !$past(frz_ff) |->
    asm71_ff[2] == $past(operation_status_word[0], 3) && asm70_ff[2] == asm71_ff[2])
    else $error("forward bit wrong");
  a_rev_follow: assert property (ok && !$past(frz_ff) |->
    asm71_ff[3] == $past(operation_status_word[1], 3))
    else $error("reverse bit wrong");
  a_ready_state: assert property (ok && !$past(frz_ff) |->
    asm71_ff[4] == ($past(drive_state) >= `DSIM_DS_READY && $past(drive_state) <= `DSIM_DS_STOPPING))
    else $error("ready bit wrong");
  a_state_byte: assert property (ok && !$past(frz_ff) |->
    asm71_ff[15:8] == $past(drive_state)) else $error("state byte wrong");
  a_at_ref: assert property (ok && !$past(frz_ff) |->
    asm71_ff[7] == (($past(operation_status_word[0], 3) | $past(operation_status_word[1], 3))
    & ~$past(operation_status_word[9], 3) & ~$past(operation_status_word[10], 3))) else $error("at-ref wrong");
  a_layout_70: assert property (asm70_ff[31:16] == asm71_ff[31:16] && asm70_ff[15:3] == 13'h0000 && !asm70_ff[1])
    else $error("instance 70 layout wrong");
  a_freeze_hold: assert property (ok && $past(frz_ff) |-> $stable(asm71_ff) && $stable(asm70_ff))
    else $error("frozen image changed");
endmodule : dsim_input_mapper_chk

bind dsim_input_mapper dsim_input_mapper_chk u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .operation_status_word(operation_status_word),
  .drive_state(drive_state), .asm71_ff(asm71_ff), .asm70_ff(asm70_ff),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

// *** tb/tb_drive_status_input_mapper.sv ***
`timescale 1ns/1ps
`include "dsim_regs.svh"
module tb_drive_status_input_mapper;
  import dsim_pkg::*;
  logic        sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_ff, net_fault;
  logic [15:0] osw = 16'h0000, freq = 16'h0000, net_speed;
  logic [7:0]  poles = 8'h04, ds = 8'h00, reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, asm71_ff, asm70_ff, rv;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, lat_poles = 4, i;

  always #2 sys_clk = ~sys_clk;

  dsim_input_mapper dut (.sys_clk(sys_clk), .reset_n(reset_n), .operation_status_word(osw),
    .output_frequency_code(freq), .motor_pole_count_setting(poles), .drive_state(ds), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .asm71_ff(asm71_ff),
    .asm70_ff(asm70_ff), .irq_ff(irq_ff));
  dsim_net_ctrl u_net (.asm_in(asm71_ff), .faulted(net_fault), .speed_rpm(net_speed));

  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Ceiling well above the ~8500 cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : rd

  task automatic boot(input logic [7:0] p);
    @(posedge sys_clk);
    poles <= p; reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    lat_poles = p;
  endtask : boot

  function automatic int spd(input int f, input int p);
    int r;
    if (p == 0) return 0;
    r = (f * 120 + p * 50) / (p * 100);
    return (r > 65535) ? 65535 : r;
  endfunction : spd

  task automatic apply(input logic [15:0] o, input logic [7:0] s, input logic [15:0] f);
    logic [15:0] sp;
    logic        rdy;
    logic        ar;
    @(posedge sys_clk);
    osw <= o; ds <= s; freq <= f;
    // Longer than two refresh periods plus the divide
    repeat (600) @(posedge sys_clk);
    @(negedge sys_clk);
    sp = 16'(spd(int'(f), lat_poles));
    rdy = (s == 8'h03) || (s == 8'h04) || (s == 8'h05);
    ar = (o[0] | o[1]) & ~o[9] & ~o[10];
    chk(asm71_ff, {sp, s, ar, 2'h0, rdy, o[1], o[0], 1'b0, o[11]});
    chk(asm70_ff, {sp, 13'h0000, o[0], 1'b0, o[11]});
    chk({16'h0000, net_speed}, {16'h0000, sp});
    chk({31'h0, net_fault}, {31'h0, o[11]});
    rd(`DSIM_REG_SPEED, rv);
    chk(rv & 32'h0000FFFF, {16'h0000, sp});
  endtask : apply

  initial
  begin
    rv = $urandom(36183);
    boot(8'h04);
    rd(`DSIM_REG_CONTROL, rv);
    chk(rv, 32'h00000001);
    rd(8'h40, rv);
    chk(rv, 32'h00000000);
    rd(`DSIM_REG_POLES, rv);
    chk(rv & 32'h000000FF, 32'h00000004);
    for (i = 0; i < 8; i++)
      apply(16'($urandom) & 16'h0E03, 8'(i), 16'($urandom_range(0, 30000)));
    // Fault low first so the next fault is a real rising edge
    apply(16'h0000, 8'h04, 16'h03E8);
    wr(`DSIM_REG_IRQ_CLEAR, 32'h0000001F);
    wr(`DSIM_REG_IRQ_ENABLE, 32'h00000001);
    apply(16'h0800, 8'h04, 16'h03E8);
    chk({31'h0, irq_ff}, 32'h00000001);
    rd(`DSIM_REG_IRQ_STATUS, rv);
    chk(rv & 32'h00000001, 32'h00000001);
    // Clear with the fault still high: no new edge, so the bit stays clear
    wr(`DSIM_REG_IRQ_CLEAR, 32'h00000001);
    rd(`DSIM_REG_IRQ_STATUS, rv);
    chk(rv & 32'h00000001, 32'h00000000);
    wr(`DSIM_REG_IRQ_ENABLE, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, irq_ff}, 32'h00000000);
    // Freeze with speed updates off: images and speed keep the last values
    wr(`DSIM_REG_CONTROL, 32'h00000002);
    @(posedge sys_clk);
    osw <= 16'h0001; ds <= 8'h03; freq <= 16'h1770;
    repeat (600) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(asm71_ff, 32'h012C0411);
    chk(asm70_ff, 32'h012C0001);
    rd(`DSIM_REG_SPEED, rv);
    chk(rv & 32'h0000FFFF, 32'h0000012C);
    wr(`DSIM_REG_CONTROL, 32'h00000001);
    // Setting changed while running must not reach the speed
    @(posedge sys_clk);
    poles <= 8'h01;
    apply(16'h0001, 8'h04, 16'h1770);
    boot(8'h01);
    apply(16'h0003, 8'h05, 16'hFFFF);
    rd(`DSIM_REG_IRQ_STATUS, rv);
    chk(rv & 32'h00000008, 32'h00000008);
    boot(8'h00);
    apply(16'h0001, 8'h03, 16'h1388);
    rd(`DSIM_REG_IRQ_STATUS, rv);
    chk(rv & 32'h00000010, 32'h00000010);
    wrap_up();
  end
endmodule : tb_drive_status_input_mapper
